// ===== serpo_consts.svh
// constants for the serial-in parallel-out shifter
`ifndef SERPO_CONSTS_SVH
`define SERPO_CONSTS_SVH

// number of stages in the shift and storage registers
`define SERPO_WIDTH        8
// index of the first shift stage (fed by the serial input)
`define SERPO_FIRST_STAGE  0
// content loaded by i_reset; stands in for an undefined power-up state
`define SERPO_POWERUP_VAL  8'hA5
// level of the edge history after reset; high blocks a false first edge
`define SERPO_EDGE_INIT    1'h1
// clock period in ns (50 MHz)
`define SERPO_CLK_PERIOD_NS 20

`endif

// ===== serpo_ctrl_model.sv
// controller model driving the shifter's data, clock and control pins
`timescale 1ns/1ps
`default_nettype none
module serpo_ctrl_model (
  // clock
  input  wire logic                  i_clk,
  // controller pins
  output var serpo_pkg::serpo_ctrl_t o_ctrl
);
  import serpo_pkg::*;
  initial begin
    o_ctrl = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  end
  // data settles a cycle ahead of the rising clock level
  task automatic pulse(input logic b, input logic shf, input logic sto);
    @(negedge i_clk);
    o_ctrl.serial_data_in = b;
    @(negedge i_clk);
    o_ctrl.shift_clock = shf;
    o_ctrl.storage_clock = sto;
    @(negedge i_clk);
    o_ctrl.shift_clock = 1'b0;
    o_ctrl.storage_clock = 1'b0;
    // data no longer held: flip it so a stale level is never reused
    o_ctrl.serial_data_in = ~b;
  endtask : pulse
  task automatic set_clear_n(input logic v);
    @(negedge i_clk);
    o_ctrl.shift_clear_n = v;
    @(negedge i_clk);
  endtask : set_clear_n
  task automatic set_enable_n(input logic v);
    @(negedge i_clk);
    o_ctrl.output_enable_n = v;
  endtask : set_enable_n
endmodule : serpo_ctrl_model
`default_nettype wire

// ===== serpo_edge_detect.sv
// rising-edge detector for a sampled clock-like input
`timescale 1ns/1ps
`default_nettype none
`include "serpo_consts.svh"

module serpo_edge_detect (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // sampled level and its rising edge
  input  wire logic i_level,
  output logic      o_rise
);

  logic prev;
  logic next_prev;

  always_comb begin
    next_prev = i_level;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prev <= `SERPO_EDGE_INIT;
    end else begin
      prev <= next_prev;
    end
  end

  // one-cycle pulse on a low-to-high change only
  assign o_rise = i_level & ~prev;

endmodule : serpo_edge_detect

`default_nettype wire

// ===== serpo_pkg.sv
// types shared by the serial-in parallel-out shifter
package serpo_pkg;

  // controller-side input pins, all but output_enable_n sampled on i_clk
  typedef struct packed {
    logic serial_data_in;
    logic shift_clock;
    logic shift_clear_n;
    logic storage_clock;
    logic output_enable_n;
  } serpo_ctrl_t;

endpackage : serpo_pkg

// ===== serpo_shifter.sv
// 8-bit serial-in shift register with storage register and 3-state outputs
`timescale 1ns/1ps
`default_nettype none
`include "serpo_consts.svh"

module serpo_shifter #(
  parameter int                 WIDTH       = `SERPO_WIDTH,
  parameter logic [WIDTH-1:0]   POWERUP_VAL = `SERPO_POWERUP_VAL
) (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  // controller pins
  input  wire serpo_pkg::serpo_ctrl_t i_ctrl,
  // parallel 3-state outputs
  output logic [WIDTH-1:0]        o_parallel_out,
  output logic [WIDTH-1:0]        o_parallel_oe,
  // cascade output
  output logic                    o_serial_out
);

  import serpo_pkg::*;

  logic [WIDTH-1:0] shift_stages;
  logic [WIDTH-1:0] storage;
  logic [WIDTH-1:0] next_shift_stages;
  logic [WIDTH-1:0] next_storage;
  logic             shift_edge;
  logic             store_edge;

  // rising edges of the two controller clocks
  serpo_edge_detect u_shift_edge (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_level (i_ctrl.shift_clock),
    .o_rise  (shift_edge)
  );

  serpo_edge_detect u_store_edge (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_level (i_ctrl.storage_clock),
    .o_rise  (store_edge)
  );

  // shift register next state
  always_comb begin
    next_shift_stages = shift_stages;
    if (!i_ctrl.shift_clear_n) begin
      next_shift_stages = '0;
    end else if (shift_edge) begin
      next_shift_stages = {shift_stages[WIDTH-2:0],
                           i_ctrl.serial_data_in};
    end
  end

  // storage next state; reads the pre-shift stages so a shared edge
  // captures old data
  always_comb begin
    next_storage = storage;
    if (store_edge) begin
      if (i_ctrl.shift_clear_n) begin
        next_storage = shift_stages;
      end else begin
        // a clear in progress reads as all zero stages
        next_storage = '0;
      end
    end
  end

  // reset loads an arbitrary pattern: contents are undefined until the
  // controller clears and stores
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      shift_stages <= POWERUP_VAL;
      storage      <= POWERUP_VAL;
    end else begin
      shift_stages <= next_shift_stages;
      storage      <= next_storage;
    end
  end

  // outputs: data from storage flops, enable straight from the pin
  assign o_parallel_out = storage;
  assign o_parallel_oe  = {WIDTH{~i_ctrl.output_enable_n}};
  assign o_serial_out   = shift_stages[WIDTH-1];

  // helper history for the checks below
  logic [WIDTH-1:0] shift_hist;
  logic [WIDTH-1:0] store_hist;
  logic             sdi_hist;

  always_ff @(posedge i_clk) begin
    shift_hist <= shift_stages;
    store_hist <= storage;
    sdi_hist   <= i_ctrl.serial_data_in;
  end

  outputs_released_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_ctrl.output_enable_n |-> (o_parallel_oe == '0))
    else $error("parallel outputs driven while disabled");

  outputs_driven_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !i_ctrl.output_enable_n |->
      (o_parallel_oe == {WIDTH{1'b1}}) && (o_parallel_out == storage))
    else $error("parallel outputs not driven from storage");

  clear_zeroes_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !i_ctrl.shift_clear_n |=> (shift_stages == '0))
    else $error("shift stages not zero after clear");

  clear_keeps_store_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (!i_ctrl.shift_clear_n && !store_edge) |=> $stable(storage))
    else $error("clear disturbed the storage register");

  held_clear_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (!i_ctrl.shift_clear_n) [*3] |-> ##1 (o_serial_out == 1'b0))
    else $error("cascade output not low during held clear");

  shift_step_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (shift_edge && i_ctrl.shift_clear_n) |=>
      (shift_stages == {shift_hist[WIDTH-2:0], sdi_hist}))
    else $error("shift did not move one stage");

  shift_hold_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (!shift_edge && i_ctrl.shift_clear_n) |=> $stable(shift_stages))
    else $error("shift stages changed without an edge");

  store_copy_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (store_edge && i_ctrl.shift_clear_n) |=> (storage == shift_hist))
    else $error("storage did not copy the shift stages");

  store_hold_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !store_edge |=> (storage == store_hist))
    else $error("storage changed without a storage edge");

  shared_edge_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (store_edge && shift_edge && i_ctrl.shift_clear_n) |=>
      (storage[WIDTH-2:0] == shift_stages[WIDTH-1:1]))
    else $error("shared edge stored post-shift data");

  rising_only_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (shift_edge |-> i_ctrl.shift_clock) and
    (store_edge |-> i_ctrl.storage_clock))
    else $error("edge detected on a low clock level");

  no_refire_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    shift_edge |=> !shift_edge)
    else $error("one clock rise counted twice");

  cascade_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (shift_edge && i_ctrl.shift_clear_n) |=>
      (o_serial_out == shift_hist[WIDTH-2]))
    else $error("cascade output not fed from previous stage");

  cascade_ungated_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_ctrl.output_enable_n |-> (o_serial_out == shift_stages[WIDTH-1]))
    else $error("cascade output gated by output enable");

  // a bit shifted in, then stored three cycles later, shows on output zero
  first_stage_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (shift_edge && i_ctrl.shift_clear_n) ##1
      (!shift_edge && !store_edge && i_ctrl.shift_clear_n) [*2] ##1
      (store_edge && !shift_edge && i_ctrl.shift_clear_n) |=>
      (o_parallel_out[`SERPO_FIRST_STAGE] == $past(sdi_hist, 3)))
    else $error("first stage not on parallel output zero");

  shift_rise_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    shift_edge |-> !$past(i_ctrl.shift_clock))
    else $error("shift edge without a low clock sample before");

  store_rise_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    store_edge |-> !$past(i_ctrl.storage_clock))
    else $error("storage edge without a low clock sample before");

  // a clear in progress reads as all zero stages
  store_clear_zero_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (store_edge && !i_ctrl.shift_clear_n) |=> (storage == '0))
    else $error("store during clear did not load zero");

  clear_beats_shift_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (shift_edge && !i_ctrl.shift_clear_n) |=> (o_serial_out == 1'b0))
    else $error("shift edge acted during clear");

  clear_keeps_oe_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !i_ctrl.shift_clear_n |->
      (o_parallel_oe == {WIDTH{~i_ctrl.output_enable_n}}))
    else $error("clear disturbed the output enable");

endmodule : serpo_shifter

`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the serial-in parallel-out shifter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import serpo_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  serpo_ctrl_t ctrl;
  logic [7:0]  pout, poe, sh, st, byte_v, r;
  logic        sout;
  wire  [7:0]  pins;
  integer      err_total = 0;
  integer      comparisons = 0;
  integer      seed = 32'hA319A71E;
  always #10 i_clk = ~i_clk;
  serpo_ctrl_model ctl (.i_clk(i_clk), .o_ctrl(ctrl));
  serpo_shifter dut (.i_clk(i_clk), .i_reset(i_reset), .i_ctrl(ctrl),
    .o_parallel_out(pout), .o_parallel_oe(poe), .o_serial_out(sout));
  for (genvar k = 0; k < 8; k++) begin : g_pin
    assign pins[k] = poe[k] ? pout[k] : 1'bz;
  end
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic check_all();
    #1;
    chk("storage", pout, st);
    chk("cascade", {7'h00, sout}, {7'h00, sh[7]});
    chk("drive", poe, {8{~ctrl.output_enable_n}});
    chk("pins", pins, ctrl.output_enable_n ? 8'hZZ : st);
  endtask : check_all
  task automatic op(input logic b, input logic shf, input logic sto);
    ctl.pulse(b, shf, sto);
    if (sto) st = ctrl.shift_clear_n ? sh : 8'h00;
    if (shf && ctrl.shift_clear_n) sh = {sh[6:0], b};
    check_all();
  endtask : op
  task automatic clr(input logic v);
    ctl.set_clear_n(v);
    if (!v) sh = 8'h00;
    check_all();
  endtask : clr
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    #80000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_reset = 1'b0;
    // known state: clear, then store while clear is low
    ctl.set_clear_n(1'b0);
    sh = 8'h00;
    op(1'b1, 1'b1, 1'b1);
    clr(1'b1);
    ctl.set_enable_n(1'b0);
    byte_v = 8'($random(seed));
    for (int i = 0; i < 8; i++) begin
      op(byte_v[7-i], 1'b1, 1'b0);
    end
    op(1'b0, 1'b0, 1'b1);
    chk("byte order", pout, byte_v);
    ctl.set_enable_n(1'b1);
    op(1'b1, 1'b1, 1'b0);
    clr(1'b0);
    clr(1'b1);
    op(1'b1, 1'b1, 1'b1);
    op(1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 60; i++) begin
      r = 8'($random(seed));
      if (r[4]) ctl.set_enable_n(r[5]);
      if (r[7:5] == 3'h0) clr(r[3]);
      else op(r[0], r[1], r[2]);
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
